//--- rtl/lmmne_params.svh
/*
  constants for the literal/move/multiply/negate execution datapath:
  opcode patterns, field positions, flag positions, timing.
  assumes inclusion by bare name from the package and rtl files.
*/
`ifndef LMMNE_PARAMS_SVH
`define LMMNE_PARAMS_SVH

// opcode patterns: whole upper byte, or its top seven bits 15:9
`define LMMNE_OP_LOADLIT   8'h0E
`define LMMNE_OP_MULLIT    8'h0D
`define LMMNE_OP_MULFILE   7'h01
`define LMMNE_OP_STORE     7'h37
`define LMMNE_OP_NEGATE    7'h36
// field positions in the instruction word
`define LMMNE_ACCESS_BIT   8
`define LMMNE_OPC7_MSB     15
`define LMMNE_OPC7_LSB     9
// highest file address routed through indexed literal offset
`define LMMNE_ILO_LIMIT    8'h5F
// status flag bit positions
`define LMMNE_FLG_C        0
`define LMMNE_FLG_DC       1
`define LMMNE_FLG_Z        2
`define LMMNE_FLG_OV       3
`define LMMNE_FLG_N        4
// reset values
`define LMMNE_RST_BYTE     8'h00
`define LMMNE_RST_FLAGS    5'h00
`define LMMNE_RST_PHASE    4'h1
// quarter phases per instruction cycle
`define LMMNE_QPHASES      4

`endif

//--- rtl/lmmne_pkg.sv
/*
  types shared by the execution datapath files.
  assumes lmmne_params.svh on the include path.
*/
`include "lmmne_params.svh"

package lmmne_pkg;

  typedef enum logic [3:0] {
    LMMNE_Q1 = 4'b0001,
    LMMNE_Q2 = 4'b0010,
    LMMNE_Q3 = 4'b0100,
    LMMNE_Q4 = 4'b1000
  } lmmne_phase_e;

  typedef enum logic [5:0] {
    LMMNE_I_NONE  = 6'b000001,
    LMMNE_I_LDLIT = 6'b000010,
    LMMNE_I_STORE = 6'b000100,
    LMMNE_I_MULL  = 6'b001000,
    LMMNE_I_MULF  = 6'b010000,
    LMMNE_I_NEG   = 6'b100000
  } lmmne_instr_e;

endpackage

//--- rtl/lmmne_negate.sv
/*
  combinational two's-complement negation with add-style flags.
  assumes the caller registers the result and flags.
*/
`include "lmmne_params.svh"

module lmmne_negate
  import lmmne_pkg::*;
(
  input  wire logic [7:0] operand,
  output logic      [7:0] result,
  output logic      [4:0] flags
);

  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [7:0] inv;

  always_comb begin
    inv    = ~operand;
    // inverted operand plus one, carries as for a plain add
    sum    = {1'b0, inv} + 9'h001;
    lowSum = {1'b0, inv[3:0]} + 5'h01;
    result = sum[7:0];
    flags  = `LMMNE_RST_FLAGS;
    flags[`LMMNE_FLG_C]  = sum[8];
    flags[`LMMNE_FLG_DC] = lowSum[4];
    flags[`LMMNE_FLG_Z]  = (sum[7:0] == 8'h00);
    flags[`LMMNE_FLG_N]  = sum[7];
    flags[`LMMNE_FLG_OV] = ~inv[7] & sum[7];
  end

endmodule

//--- rtl/lmmne_exec.sv
/*
  execution datapath for load literal, store work, two multiplies and
  negate. one instruction per four quarter phases.
  assumes the decoder holds instrWord stable and raises instrValid at Q1;
  the file-space answer readData is valid from Q3 of a read cycle.
*/
`include "lmmne_params.svh"

module lmmne_exec
  import lmmne_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic        extendedEn,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [7:0]  readData,
  output logic             fileRead,
  output logic             fileWrite,
  output logic             indexedMode,
  output logic             accessBank,
  output logic [3:0]       bankOut,
  output logic [7:0]       fileAddr,
  output logic [7:0]       writeData,
  output logic [7:0]       workReg,
  output logic [7:0]       productHighByte,
  output logic [7:0]       productLowByte,
  output logic [4:0]       statusFlags,
  output logic [3:0]       phase,
  output logic             busy
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic lmmne_instr_e decode(input logic [15:0] w);
    lmmne_instr_e r;
    r = LMMNE_I_NONE;
    if (w[15:8] == `LMMNE_OP_LOADLIT) begin
      r = LMMNE_I_LDLIT;
    end else if (w[15:8] == `LMMNE_OP_MULLIT) begin
      r = LMMNE_I_MULL;
    end else if (w[`LMMNE_OPC7_MSB:`LMMNE_OPC7_LSB] == `LMMNE_OP_MULFILE) begin
      r = LMMNE_I_MULF;
    end else if (w[`LMMNE_OPC7_MSB:`LMMNE_OPC7_LSB] == `LMMNE_OP_STORE) begin
      r = LMMNE_I_STORE;
    end else if (w[`LMMNE_OPC7_MSB:`LMMNE_OPC7_LSB] == `LMMNE_OP_NEGATE) begin
      r = LMMNE_I_NEG;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lmmne_phase_e phase_reg, phase_next;
  lmmne_instr_e instr_reg, instr_next;
  logic [7:0]  literal_reg, literal_next;
  logic [7:0]  work_reg, work_next;
  logic [7:0]  prodHi_reg, prodHi_next;
  logic [7:0]  prodLo_reg, prodLo_next;
  logic [4:0]  flags_reg, flags_next;
  logic [7:0]  operand_reg, operand_next;
  logic        rd_reg, rd_next;
  logic        wr_reg, wr_next;
  logic        idx_reg, idx_next;
  logic        acc_reg, acc_next;
  logic [3:0]  bank_reg, bank_next;
  logic [7:0]  addr_reg, addr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        busy_reg, busy_next;

  logic [7:0]  negResult;
  logic [4:0]  negFlags;
  logic [15:0] product;
  logic        fileOp;
  logic        accessBit;
  lmmne_instr_e dec;

  lmmne_negate u_negate (
    .operand (operand_reg),
    .result  (negResult),
    .flags   (negFlags)
  );

  always_comb begin
    dec       = decode(instrWord);
    accessBit = instrWord[`LMMNE_ACCESS_BIT];
    fileOp    = (dec == LMMNE_I_STORE) || (dec == LMMNE_I_MULF)
                || (dec == LMMNE_I_NEG);
    product   = work_reg * operand_reg;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    phase_next   = phase_reg;
    instr_next   = instr_reg;
    literal_next = literal_reg;
    work_next    = work_reg;
    prodHi_next  = prodHi_reg;
    prodLo_next  = prodLo_reg;
    flags_next   = flags_reg;
    operand_next = operand_reg;
    rd_next      = 1'b0;
    wr_next      = 1'b0;
    idx_next     = idx_reg;
    acc_next     = acc_reg;
    bank_next    = bank_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    busy_next    = busy_reg;
    case (phase_reg)
      LMMNE_Q1: begin
        // decode; idle cycles stay in Q1 until an instruction arrives
        if (instrValid) begin
          instr_next   = dec;
          literal_next = instrWord[7:0];
          addr_next    = instrWord[7:0];
          acc_next     = ~accessBit;
          bank_next    = accessBit ? bankSelect : 4'h0;
          idx_next     = fileOp && !accessBit && extendedEn
                         && (instrWord[7:0] <= `LMMNE_ILO_LIMIT);
          busy_next    = 1'b1;
          phase_next   = LMMNE_Q2;
          rd_next      = (dec == LMMNE_I_MULF) || (dec == LMMNE_I_NEG);
        end
      end
      LMMNE_Q2: begin
        // operand load: literal here; file data replaces it in Q3
        operand_next = literal_reg;
        if (rd_reg) begin
          rd_next = 1'b1;
        end
        phase_next = LMMNE_Q3;
      end
      LMMNE_Q3: begin
        if (instr_reg == LMMNE_I_MULF || instr_reg == LMMNE_I_NEG) begin
          operand_next = readData;
        end
        phase_next = LMMNE_Q4;
      end
      LMMNE_Q4: begin
        case (instr_reg)
          LMMNE_I_LDLIT: work_next = literal_reg;
          LMMNE_I_STORE: begin
            wdata_next = work_reg;
            wr_next    = 1'b1;
          end
          LMMNE_I_MULL, LMMNE_I_MULF: begin
            // flags_reg untouched: no zero detection on product
            prodHi_next = product[15:8];
            prodLo_next = product[7:0];
          end
          LMMNE_I_NEG: begin
            wdata_next = negResult;
            wr_next    = 1'b1;
            flags_next = negFlags;
          end
          default: begin
          end
        endcase
        busy_next  = 1'b0;
        phase_next = LMMNE_Q1;
      end
      default: phase_next = LMMNE_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg   <= LMMNE_Q1;
      instr_reg   <= LMMNE_I_NONE;
      literal_reg <= `LMMNE_RST_BYTE;
      work_reg    <= `LMMNE_RST_BYTE;
      prodHi_reg  <= `LMMNE_RST_BYTE;
      prodLo_reg  <= `LMMNE_RST_BYTE;
      flags_reg   <= `LMMNE_RST_FLAGS;
      operand_reg <= `LMMNE_RST_BYTE;
      rd_reg      <= 1'b0;
      wr_reg      <= 1'b0;
      idx_reg     <= 1'b0;
      acc_reg     <= 1'b0;
      bank_reg    <= 4'h0;
      addr_reg    <= `LMMNE_RST_BYTE;
      wdata_reg   <= `LMMNE_RST_BYTE;
      busy_reg    <= 1'b0;
    end else if (clkEn) begin
      phase_reg   <= phase_next;
      instr_reg   <= instr_next;
      literal_reg <= literal_next;
      work_reg    <= work_next;
      prodHi_reg  <= prodHi_next;
      prodLo_reg  <= prodLo_next;
      flags_reg   <= flags_next;
      operand_reg <= operand_next;
      rd_reg      <= rd_next;
      wr_reg      <= wr_next;
      idx_reg     <= idx_next;
      acc_reg     <= acc_next;
      bank_reg    <= bank_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      busy_reg    <= busy_next;
    end
  end

  always_comb begin
    fileRead        = rd_reg;
    fileWrite       = wr_reg;
    indexedMode     = idx_reg;
    accessBank      = acc_reg;
    bankOut         = bank_reg;
    fileAddr        = addr_reg;
    writeData       = wdata_reg;
    workReg         = work_reg;
    productHighByte = prodHi_reg;
    productLowByte  = prodLo_reg;
    statusFlags     = flags_reg;
    phase           = phase_reg;
    busy            = busy_reg;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_load_literal: assert property (clkEn && phase_reg == LMMNE_Q4
    && instr_reg == LMMNE_I_LDLIT |=> work_reg == $past(literal_reg)
    && $stable(flags_reg)) else $error("literal not loaded");
  a_store_write: assert property (clkEn && phase_reg == LMMNE_Q4
    && instr_reg == LMMNE_I_STORE |=> wr_reg
    && wdata_reg == $past(work_reg) && $stable(flags_reg))
    else $error("store wrong");
  a_bank_select: assert property (clkEn && phase_reg == LMMNE_Q1
    && instrValid |=> acc_reg == !$past(instrWord[8])
    && (acc_reg || bank_reg == $past(bankSelect)))
    else $error("bank select wrong");
  a_indexed_mode: assert property (idx_reg |-> acc_reg
    && addr_reg <= `LMMNE_ILO_LIMIT) else $error("indexed mode wrong");
  a_mult_product: assert property (clkEn && phase_reg == LMMNE_Q4
    && (instr_reg == LMMNE_I_MULL || instr_reg == LMMNE_I_MULF)
    |=> {prodHi_reg, prodLo_reg} == $past(work_reg) * $past(operand_reg))
    else $error("product wrong");
  a_mult_flags: assert property ((instr_reg == LMMNE_I_MULL
    || instr_reg == LMMNE_I_MULF) && phase_reg == LMMNE_Q4
    |=> $stable(flags_reg)) else $error("multiply touched flags");
  a_mult_keep: assert property (instr_reg == LMMNE_I_MULF
    && phase_reg == LMMNE_Q4 |=> $stable(work_reg) && !wr_reg)
    else $error("file multiply wrote work or file");
  a_neg_result: assert property (clkEn && phase_reg == LMMNE_Q4
    && instr_reg == LMMNE_I_NEG |=> wr_reg
    && wdata_reg == 8'(-$past(operand_reg))
    && flags_reg[`LMMNE_FLG_Z] == (wdata_reg == 8'h00))
    else $error("negate wrong");
  a_phase_walk: assert property (clkEn && phase_reg == LMMNE_Q2
    ##1 clkEn[*2] |=> phase_reg == LMMNE_Q1) else $error("phase walk");

  c_negate: cover property (phase_reg == LMMNE_Q4 && instr_reg == LMMNE_I_NEG);
  c_mulfile: cover property (phase_reg == LMMNE_Q4
    && instr_reg == LMMNE_I_MULF);
  c_indexed: cover property (idx_reg && busy_reg);

endmodule

//--- dv/lmmne_file_model.sv
/*
  file-space model facing the execution datapath: answers reads and
  takes writes. assumes the bench preloads mem by hierarchical access.
*/
module lmmne_file_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       fileRead,
  input  wire logic       fileWrite,
  input  wire logic [7:0] fileAddr,
  input  wire logic [7:0] writeData,
  output logic      [7:0] readData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] lastRd;
  // released bus shows the inverse of the last answer
  assign readData = fileRead ? mem[fileAddr] : ~lastRd;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastRd <= 8'h00;
    end else begin
      if (fileRead) begin
        lastRd <= mem[fileAddr];
      end
      if (fileWrite) begin
        mem[fileAddr] <= writeData;
      end
    end
  end
endmodule

//--- dv/tb_top.sv
/*
  self-checking bench for lmmne_exec: driver notes expectations in a
  queue, a monitor compares them when an instruction completes.
  assumes lmmne_pkg compiled and lmmne_params.svh on the include path.
*/
module tb_top
  import lmmne_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] w, ph, pl, wd, ad;
    logic [4:0] fl;
    logic [3:0] bk;
    logic       wr, idx, acc, fo, rd;
  } lmmne_note_s;
  logic clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, instrValid = 1'b0;
  logic extendedEn = 1'b0, fileRead, fileWrite, indexedMode, accessBank;
  logic busy, prevBusy = 1'b0, sawRead = 1'b0, prevEn = 1'b1;
  logic [3:0]  prevPhase = 4'h1;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0]  bankSelect = 4'h0, bankOut, phase;
  logic [7:0]  readData, fileAddr, writeData, workReg, product_high_byte, product_low_byte;
  logic [7:0]  eW = 8'h00, eH = 8'h00, eL = 8'h00;
  logic [4:0]  statusFlags, eFl = 5'h00;
  int err_count = 0, compares = 0, cyc = 0, seed = 40;
  lmmne_note_s notes[$];
  always #50 clk = ~clk;
  lmmne_exec lmmne_exec_i (.clk(clk), .arst_n(arst_n), .clkEn(clkEn),
    .instrValid(instrValid), .instrWord(instrWord),
    .extendedEn(extendedEn), .bankSelect(bankSelect),
    .readData(readData), .fileRead(fileRead), .fileWrite(fileWrite),
    .indexedMode(indexedMode), .accessBank(accessBank),
    .bankOut(bankOut), .fileAddr(fileAddr), .writeData(writeData),
    .workReg(workReg), .productHighByte(product_high_byte), .productLowByte(product_low_byte),
    .statusFlags(statusFlags), .phase(phase), .busy(busy));
  lmmne_file_model lmmne_file_model_i (.clk(clk), .arst_n(arst_n),
    .fileRead(fileRead), .fileWrite(fileWrite), .fileAddr(fileAddr),
    .writeData(writeData), .readData(readData));
  // ----------------------------------------
  // compare and close
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // driver with expectation notes
  // ----------------------------------------
  task automatic issue(input logic [15:0] iw, input logic ext,
                       input logic [3:0] bs, input logic [7:0] fv,
                       input int st = 0);
    lmmne_note_s n;
    logic [8:0]  s;
    n = '{default: '0};
    if (iw[15:8] == 8'h0E) begin
      eW = iw[7:0];
    end else if (iw[15:8] == 8'h0D) begin
      {eH, eL} = eW * iw[7:0];
    end else if (iw[15:9] == 7'h01) begin
      {n.fo, n.rd} = 2'b11;
      {eH, eL} = eW * fv;
    end else if (iw[15:9] == 7'h37) begin
      {n.fo, n.wr, n.wd} = {2'b11, eW};
    end else if (iw[15:9] == 7'h36) begin
      s = {1'b0, ~fv} + 9'h001;
      {n.fo, n.rd, n.wr, n.wd} = {3'b111, s[7:0]};
      eFl = {s[7], fv == 8'h80, s[7:0] == 8'h00, fv[3:0] == 4'h0, s[8]};
    end
    {n.w, n.ph, n.pl, n.fl, n.ad} = {eW, eH, eL, eFl, iw[7:0]};
    n.acc = ~iw[8];
    n.bk  = iw[8] ? bs : 4'h0;
    n.idx = n.fo & ~iw[8] & ext & (iw[7:0] <= 8'h5F);
    notes.push_back(n);
    @(posedge clk);
    {instrValid, instrWord, extendedEn, bankSelect} <= {1'b1, iw, ext, bs};
    @(posedge clk);
    instrValid <= 1'b0;
    // optional stall: clock enable low for st cycles after the take edge
    if (st != 0) begin
      clkEn <= 1'b0;
      repeat (st) @(posedge clk);
      clkEn <= 1'b1;
    end
    @(negedge clk);
    lmmne_file_model_i.mem[iw[7:0]] = fv;
    repeat (2) @(posedge clk);
  endtask
  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(negedge clk) begin
    lmmne_note_s n;
    if (prevBusy === 1'b1 && busy === 1'b0) begin
      if (notes.size() == 0) begin
        check("spare result", 16'h0001, 16'h0000);
      end else begin
        n = notes.pop_front();
        check("workReg", workReg, n.w);
        check("product_high_byte", product_high_byte, n.ph);
        check("product_low_byte", product_low_byte, n.pl);
        check("flags", statusFlags, n.fl);
        check("phase", phase, LMMNE_Q1);
        check("fileRead", sawRead, n.rd);
        sawRead = 1'b0;
        check("fileWrite", fileWrite, n.wr);
        if (n.wr) check("writeData", writeData, n.wd);
        if (n.fo) begin
          check("fileAddr", fileAddr, n.ad);
          check("accessBank", accessBank, n.acc);
          check("bankOut", bankOut, n.bk);
          check("indexedMode", indexedMode, n.idx);
        end
      end
    end
    if (prevEn === 1'b0) begin
      check("frozen phase", phase, prevPhase);
    end
    if (busy === 1'b1 && fileRead === 1'b1) begin
      sawRead = 1'b1;
    end
    prevBusy = busy;
    prevPhase = phase;
    prevEn = clkEn;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [15:0] iw;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("reset", {workReg, 4'h0, phase}, 16'h0001);
    issue(16'h0EE2, 1'b0, 4'h3, 8'h11);
    issue(16'h0DC4, 1'b0, 4'h3, 8'h22);
    issue(16'h0E00, 1'b1, 4'h5, 8'h33);
    // zero flag still clear here, so a zero product that sets it shows
    issue(16'h0D55, 1'b1, 4'h5, 8'h44);
    issue(16'h6C10, 1'b0, 4'h5, 8'h00);
    issue(16'h6D70, 1'b1, 4'hA, 8'h80);
    issue(16'h6C5F, 1'b1, 4'hA, 8'h3A);
    issue(16'h0EC4, 1'b0, 4'h1, 8'h00);
    issue(16'h03B5, 1'b0, 4'hF, 8'hB5, 3);
    issue(16'h6E60, 1'b1, 4'h7, 8'h55);
    issue(16'h6E5F, 1'b1, 4'h7, 8'h66);
    for (int i = 0; i < 80; i++) begin
      v = $random(seed);
      case (v[31:29] % 3'd5)
        3'd0: iw = {8'h0E, v[7:0]};
        3'd1: iw = {8'h0D, v[7:0]};
        3'd2: iw = {7'h01, v[8], v[7:0]};
        3'd3: iw = {7'h37, v[8], v[7:0]};
        default: iw = {7'h36, v[8], v[7:0]};
      endcase
      issue(iw, v[24], v[28:25], v[23:16], v[15:14]);
    end
    repeat (6) @(posedge clk);
    check("pending notes", 16'(notes.size()), 16'h0000);
    final_report();
  end
endmodule
